// ==== dv/tip_pin_model.sv ====
/*
 * external hardware on the pin bank: drives released pins and the strobe.
 * assumes the bench updates its controls by non-blocking assignment.
 */
`timescale 1ns/100ps
module tip_pin_model (
    // device side
    input logic [31:0] pin_out_ff,
    input logic [31:0] pin_oe_ff,
    // bench controls
    input logic [31:0] ext_val,
    input logic ext_strb,
    // wire levels seen by the device
    output logic [31:0] pin_in,
    output logic strobe_input
);
    // released pins show the far side's own word, never a stale drive
    assign pin_in = (pin_oe_ff & pin_out_ff) | (~pin_oe_ff & ext_val);
    assign strobe_input = ext_strb;
endmodule

// ==== dv/tip_port_ctl_asserts.sv ====
/*
 * port-level assertions for the timed pin port block.
 * assumes core_clk with synchronous active-low rst_b; bound to the top.
 */
`timescale 1ns/100ps
module tip_port_ctl_asserts (
    // clock and reset
    input logic core_clk,
    input logic rst_b,
    // pins and link
    input logic [31:0] pin_out_ff,
    input logic [31:0] pin_oe_ff,
    input logic strobe_output_ff,
    input logic link_en,
    input logic [31:0] link_pin_mask,
    // configuration
    input logic [4:0] cfg_en,
    input logic [4:0] cfg_out,
    input logic [4:0] cfg_oc,
    input logic [4:0] cfg_strb_out,
    // core side
    input logic core_req,
    input logic [2:0] core_sel,
    input logic core_ack_ff,
    input logic core_ok_ff,
    input logic [4:0] port_evt_ff
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    ack_follows_req_a: assert property (core_req |=> core_ack_ff)
        else $error("no answer one cycle after a command");
    ack_has_cause_a: assert property (!core_req |=> !core_ack_ff)
        else $error("answer without a command");
    ok_with_ack_a: assert property (core_ok_ff |-> core_ack_ff)
        else $error("accept flag outside an answer");
    bad_sel_refused_a: assert property (
        core_req && core_sel > 3'h4 |=> !core_ok_ff)
        else $error("command to a missing port accepted");
    link_pins_free_a: assert property (
        link_en && $past(link_en) && $stable(link_pin_mask)
        |-> (pin_oe_ff & link_pin_mask) == 32'h0)
        else $error("port drives a pin held by the link");
    oc_never_high_a: assert property (
        cfg_en != 5'h0 && (cfg_en & cfg_oc) == cfg_en && $stable(cfg_en)
        && $stable(cfg_oc) |-> (pin_out_ff & pin_oe_ff) == 32'h0)
        else $error("open collector pin driven high");
    all_input_quiet_a: assert property (
        (cfg_en & cfg_out) == 5'h0 && $stable(cfg_en) && $stable(cfg_out)
        |-> pin_oe_ff == 32'h0)
        else $error("pin driven with no output port");
    narrow_owns_pin_a: assert property (
        cfg_en[0] && !cfg_out[0] && $stable(cfg_en) && $stable(cfg_out)
        |-> !pin_oe_ff[0])
        else $error("wider port drives pin of narrow input");
    strobe_cause_a: assert property (
        strobe_output_ff
        |-> $past(cfg_en & cfg_out & cfg_strb_out, 2) != 5'h0)
        else $error("output strobe with no strobing port");
    evt_enabled_a: assert property (
        port_evt_ff != 5'h0 |-> (port_evt_ff & ~cfg_en) == 5'h0)
        else $error("event from a disabled port");
endmodule

bind tip_port_ctl tip_port_ctl_asserts u_chk (.core_clk, .rst_b,
    .pin_out_ff, .pin_oe_ff, .strobe_output_ff, .link_en, .link_pin_mask,
    .cfg_en, .cfg_out, .cfg_oc, .cfg_strb_out, .core_req, .core_sel,
    .core_ack_ff, .core_ok_ff, .port_evt_ff);

// ==== dv/tip_port_ctl_test.sv ====
/*
 * self-checking bench for the timed pin port block.
 * assumes the pin model on the bank and the bound assertion checker.
 */
`timescale 1ns/100ps
module tip_port_ctl_test;
    typedef struct {
        logic ok;
        logic [31:0] rd;
        logic [31:0] msk;
        bit dlt;
    } tip_exp_t;
    logic core_clk, rst_b, strobe_input, strobe_output_ff, ext_strb, link_en;
    logic [31:0] pin_in, pin_out_ff, pin_oe_ff, ext_val, link_pin_mask;
    logic [4:0] cfg_en, cfg_out, cfg_oc, cfg_strb_in, cfg_strb_out;
    logic [4:0] port_evt_ff;
    logic [9:0] cfg_cond_mode;
    logic [5:0] cfg_clkb_ext;
    logic [47:0] cfg_clkb_div;
    logic core_req, core_ack_ff, core_ok_ff;
    logic [2:0] core_sel;
    tip_pkg::tip_cmd_t core_cmd;
    logic [31:0] core_wdata, core_rdata_ff, prv, d;
    logic [15:0] core_ts_ff, t;
    tip_exp_t expq[$];
    tip_exp_t e;
    int err_count, checks;
    integer seed;

    tip_port_ctl dut (.core_clk, .rst_b, .pin_in, .pin_out_ff, .pin_oe_ff,
        .strobe_input, .strobe_output_ff, .link_en, .link_pin_mask, .cfg_en,
        .cfg_out, .cfg_oc, .cfg_strb_in, .cfg_strb_out, .cfg_cond_mode,
        .cfg_clkb_ext, .cfg_clkb_div, .core_req, .core_sel, .core_cmd,
        .core_wdata, .core_ack_ff, .core_ok_ff, .core_rdata_ff, .core_ts_ff,
        .port_evt_ff);
    tip_pin_model far_end (.pin_out_ff, .pin_oe_ff, .ext_val, .ext_strb,
        .pin_in, .strobe_input);

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // request held until the taking edge; next call keeps req high
    task automatic cmd(input logic [2:0] sel, input tip_pkg::tip_cmd_t c,
                       input logic [31:0] wd, input logic ok,
                       input logic [31:0] rd, input logic [31:0] msk,
                       input bit dlt);
        core_req <= 1'b1;
        core_sel <= sel;
        core_cmd <= c;
        core_wdata <= wd;
        expq.push_back(tip_exp_t'{ok, rd, msk, dlt});
        @(posedge core_clk);
    endtask

    task automatic idle(input int n);
        core_req <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask

    // bounded look for an event bit (k<5) or the output strobe (k=5)
    task automatic watch(input int k, input int lim, input logic want);
        logic hit;
        hit = 1'b0;
        repeat (lim) begin
            @(posedge core_clk);
            if (k < 5 ? port_evt_ff[k] === 1'b1 : strobe_output_ff === 1'b1)
                hit = 1'b1;
        end
        check("event seen", {31'h0, hit}, {31'h0, want});
    endtask

    always @(posedge core_clk) begin
        if (rst_b === 1'b1 && core_ack_ff === 1'b1) begin
            if (expq.size() == 0) begin
                check("unexpected answer", 32'h0, 32'h1);
            end else begin
                e = expq.pop_front();
                check("accept", {31'h0, core_ok_ff}, {31'h0, e.ok});
                if (e.dlt)
                    check("count step", core_rdata_ff - prv, e.rd);
                else if (e.msk != 32'h0)
                    check("read data", core_rdata_ff & e.msk, e.rd);
            end
            prv = core_rdata_ff;
        end
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        check("run time", 32'h0, 32'h1);
        complete_run();
    end

    initial begin
        seed = 32'hACEA9FA2;
        {err_count, checks, prv, d} = '0;
        {rst_b, core_req, core_sel, core_wdata, link_en, link_pin_mask} = '0;
        core_cmd = tip_pkg::TIP_CMD_OUT;
        {cfg_en, cfg_out, cfg_oc, cfg_strb_in, cfg_strb_out} = '0;
        {cfg_cond_mode, cfg_clkb_ext, cfg_clkb_div, ext_val, ext_strb} = '0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        check("drive after reset", pin_oe_ff, 32'h0);
        // every command code to a missing port
        for (int i = 0; i < 6; i++)
            cmd(3'(5 + i % 3), tip_pkg::tip_cmd_t'(i), 32'h0, 0, 0, 0, 0);
        idle(2);
        cfg_en <= 5'h05;
        cfg_out <= 5'h04;
        cfg_strb_out <= 5'h04;
        ext_val <= $random(seed);
        d = $random(seed);
        idle(3);
        cmd(3'h2, tip_pkg::TIP_CMD_OUT, d, 1, 0, 0, 0);
        idle(0);
        watch(5, 8, 1);
        idle(1);
        check("pin data", pin_out_ff & 32'hFE, d & 32'hFE);
        check("pin enable", pin_oe_ff, 32'hFE);
        cmd(3'h0, tip_pkg::TIP_CMD_OUT, d, 0, 0, 0, 0);
        cmd(3'h2, tip_pkg::TIP_CMD_IN, 0, 0, 0, 0, 0);
        cmd(3'h2, tip_pkg::TIP_CMD_GET_COUNT, 0, 1, 0, 0, 0);
        cmd(3'h2, tip_pkg::TIP_CMD_GET_COUNT, 0, 1, 1, 0, 1);
        idle(1);
        link_en <= 1'b1;
        link_pin_mask <= 32'h0000000F;
        idle(3);
        check("link pins", pin_oe_ff, 32'h000000F0);
        link_en <= 1'b0;
        cfg_en <= 5'h02;
        cfg_out <= 5'h02;
        cfg_oc <= 5'h02;
        cfg_strb_out <= 5'h00;
        idle(3);
        cmd(3'h1, tip_pkg::TIP_CMD_OUT, 32'h0000000A, 1, 0, 0, 0);
        idle(0);
        watch(1, 8, 1);
        idle(2);
        check("oc enable", pin_oe_ff, 32'h00000005);
        check("oc level", pin_out_ff, 32'h0);
        cfg_en <= 5'h08;
        cfg_out <= 5'h00;
        cfg_oc <= 5'h00;
        cfg_strb_in <= 5'h08;
        d = $random(seed);
        ext_val <= d;
        idle(3);
        watch(3, 12, 0);
        cmd(3'h3, tip_pkg::TIP_CMD_IN, 0, 0, 0, 0, 0);
        idle(0);
        ext_strb <= 1'b1;
        watch(3, 8, 1);
        ext_strb <= 1'b0;
        cmd(3'h3, tip_pkg::TIP_CMD_IN, 0, 1, d & 32'hFFFF, 32'hFFFF,
            0);
        idle(3);
        // block 1 on pin 0, divide by two: 8 rising edges give 4 ticks
        ext_val <= 32'h0;
        cfg_clkb_ext <= 6'h02;
        cfg_clkb_div <= 48'h0000_0000_0100;
        cmd(3'h1, tip_pkg::TIP_CMD_SET_CLKB, 32'h1, 1, 0, 0, 0);
        idle(4);
        cmd(3'h1, tip_pkg::TIP_CMD_GET_COUNT, 0, 1, 0, 0, 0);
        idle(3);
        repeat (8) begin
            ext_val <= 32'h1;
            idle(3);
            ext_val <= 32'h0;
            idle(3);
        end
        cmd(3'h1, tip_pkg::TIP_CMD_GET_COUNT, 0, 1, 32'h4, 0, 1);
        // port 4 holds off until its pins equal the programmed word
        d = $random(seed);
        ext_val <= ~d;
        cfg_cond_mode <= 10'h100;
        cmd(3'h4, tip_pkg::TIP_CMD_SET_COND, d, 1, 0, 0, 0);
        idle(3);
        cfg_en <= 5'h10;
        watch(4, 10, 0);
        ext_val <= d;
        watch(4, 8, 1);
        cmd(3'h4, tip_pkg::TIP_CMD_IN, 0, 1, d, 32'hFFFFFFFF, 0);
        idle(3);
        // a set time holds the drive back; the timestamp is that time
        cfg_cond_mode <= 10'h000;
        cfg_en <= 5'h04;
        cfg_out <= 5'h04;
        cmd(3'h2, tip_pkg::TIP_CMD_GET_COUNT, 0, 1, 0, 0, 0);
        idle(2);
        t = prv[15:0] + 16'h0028;
        cmd(3'h2, tip_pkg::TIP_CMD_SET_TIME, {16'h0, t}, 1, 0, 0,
            0);
        cmd(3'h2, tip_pkg::TIP_CMD_OUT, d, 1, 0, 0, 0);
        idle(0);
        watch(2, 30, 0);
        watch(2, 12, 1);
        check("timestamp", {16'h0, core_ts_ff}, {16'h0, t});
        idle(3);
        check("pending answers", 32'(expq.size()), 32'h0);
        complete_run();
    end
endmodule

// ==== logic/tip_pkg.sv ====
/*
 * shared constants and types of the timed pin port block.
 * assumes one core clock; pins and strobe arrive asynchronously.
 */
package tip_pkg;
    localparam int NPORT = 5;
    localparam int NCLKB = 6;
    localparam int PIN_W = 32;
    localparam int CNT_W = 16;
    localparam int SEL_W = 3;
    localparam int DIV_W = 8;
    // widths of the five ports, narrowest first
    localparam int PORT_W [NPORT] = '{1, 4, 8, 16, 32};
    // pin that serves as the one-bit clock source port
    localparam int CLK_SRC_PIN = 0;
    localparam logic [SEL_W-1:0] CLKB_RST = 3'h0;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
    localparam logic [PIN_W-1:0] DATA_RST = 32'h0000_0000;

    typedef enum logic [2:0] {
        TIP_CMD_OUT,
        TIP_CMD_IN,
        TIP_CMD_SET_TIME,
        TIP_CMD_SET_COND,
        TIP_CMD_GET_COUNT,
        TIP_CMD_SET_CLKB
    } tip_cmd_t;

    typedef enum logic [1:0] {
        TIP_COND_NONE,
        TIP_COND_EQ,
        TIP_COND_NEQ
    } tip_cond_t;
endpackage

// ==== logic/tip_port_ctl.sv ====
/*
 * five timed pin ports of one tile sharing a 32-pin bank, with six
 * clock blocks, serdes plus transfer buffering, counters, timestamps,
 * condition matching and strobes.
 * assumes the core issues one command per cycle and the pins, the
 * strobe input and the external clock are asynchronous to core_clk.
 */
//
// Contract
// - ports of widths 1, 4, 8, 16, 32
// - each port is wholly input or output
// - drive pins or sample with optional condition
// - every core access finishes in one cycle
// - open collector: zero drives low, one floats
// - data passes serdes then transfer register (outputs here go transfer register then serdes)
// - sixteen-bit counter times each port transfer
// - counter readable; transfer waits for set time
// - counter captured as timestamp every transfer
// - enabled link disconnects ports from its pins
// - narrower enabled port owns shared pins
// - unshared pins stay with the wider port
// - port always transfers at full width
// - six clock blocks; block 0 is reference
// - blocks 1 to 5 run at other rates
// - block may take one-bit port as clock
// - optional divider on the port clock
// - input strobe qualifies sampling of data
// - output strobe marks valid driven data
// - reset attaches every port to block 0
// - pin events go straight to scheduler
`timescale 1ns/100ps
module tip_port_ctl (
    // clock and reset
    input  logic core_clk,
    input  logic rst_b,
    // pin bank
    input  logic [tip_pkg::PIN_W-1:0] pin_in,
    output logic [tip_pkg::PIN_W-1:0] pin_out_ff,
    output logic [tip_pkg::PIN_W-1:0] pin_oe_ff,
    input  logic strobe_input,
    output logic strobe_output_ff,
    // link sharing the low pins
    input  logic link_en,
    input  logic [tip_pkg::PIN_W-1:0] link_pin_mask,
    // per-port configuration, one bit or field per port
    input  logic [tip_pkg::NPORT-1:0] cfg_en,
    input  logic [tip_pkg::NPORT-1:0] cfg_out,
    input  logic [tip_pkg::NPORT-1:0] cfg_oc,
    input  logic [tip_pkg::NPORT-1:0] cfg_strb_in,
    input  logic [tip_pkg::NPORT-1:0] cfg_strb_out,
    input  logic [2*tip_pkg::NPORT-1:0] cfg_cond_mode,
    // clock block configuration, blocks 1 to 5
    input  logic [tip_pkg::NCLKB-1:0] cfg_clkb_ext,
    input  logic [tip_pkg::NCLKB*tip_pkg::DIV_W-1:0] cfg_clkb_div,
    // core command port
    input  logic core_req,
    input  logic [tip_pkg::SEL_W-1:0] core_sel,
    input  tip_pkg::tip_cmd_t core_cmd,
    input  logic [tip_pkg::PIN_W-1:0] core_wdata,
    output logic core_ack_ff,
    output logic core_ok_ff,
    output logic [tip_pkg::PIN_W-1:0] core_rdata_ff,
    output logic [tip_pkg::CNT_W-1:0] core_ts_ff,
    // events to the scheduler
    output logic [tip_pkg::NPORT-1:0] port_evt_ff
);
    localparam int NP = tip_pkg::NPORT;
    localparam int NB = tip_pkg::NCLKB;
    localparam int PW = tip_pkg::PIN_W;
    localparam int CW = tip_pkg::CNT_W;
    localparam int DW = tip_pkg::DIV_W;

    logic [PW-1:0] pin_s1_ff;
    logic [PW-1:0] pin_s2_ff;
    logic strb_s1_ff;
    logic strb_s2_ff;
    logic ext_prev_ff;
    logic [NB-1:0] clkb_tick;
    logic [NB-1:0][DW-1:0] div_cnt_ff;
    logic [NP-1:0][PW-1:0] xfer_ff;
    logic [NP-1:0][PW-1:0] sd_ff;
    logic [NP-1:0][PW-1:0] drv_ff;
    logic [NP-1:0][CW-1:0] cnt_ff;
    logic [NP-1:0][CW-1:0] ts_ff;
    logic [NP-1:0][CW-1:0] time_ff;
    logic [NP-1:0][PW-1:0] cond_ff;
    logic [NP-1:0][tip_pkg::SEL_W-1:0] clkb_sel_ff;
    logic [NP-1:0] full_ff;
    logic [NP-1:0] sd_full_ff;
    logic [NP-1:0] timed_ff;
    logic [NP-1:0] strb_pulse_ff;
    logic [NP-1:0] acc;
    logic ext_rise;
    logic [PW-1:0] nxt_pin_out;
    logic [PW-1:0] nxt_pin_oe;
    logic [PW-1:0] nxt_rdata;
    logic [CW-1:0] nxt_ts;

    // pins and strobe are asynchronous: two stages before use
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pin_s1_ff <= tip_pkg::DATA_RST;
            pin_s2_ff <= tip_pkg::DATA_RST;
            strb_s1_ff <= 1'b0;
            strb_s2_ff <= 1'b0;
            ext_prev_ff <= 1'b0;
        end else begin
            pin_s1_ff <= pin_in;
            pin_s2_ff <= pin_s1_ff;
            strb_s1_ff <= strobe_input;
            strb_s2_ff <= strb_s1_ff;
            ext_prev_ff <= pin_s2_ff[tip_pkg::CLK_SRC_PIN];
        end
    end

    // edge of the one-bit clock source port
    assign ext_rise = pin_s2_ff[tip_pkg::CLK_SRC_PIN]
        && !ext_prev_ff;

    genvar b;
    generate
        for (b = 0; b < NB; b++) begin : g_clkb
            logic src_edge;
            logic [DW-1:0] div;
            // block 0 is the reference: no divider, ticks every cycle
            assign div = (b == 0) ? tip_pkg::DIV_RST
                : cfg_clkb_div[b*DW +: DW];
            assign src_edge = (b != 0 && cfg_clkb_ext[b]) ? ext_rise
                : 1'b1;
            // divide 0 passes every source edge
            assign clkb_tick[b] = src_edge
                && (div_cnt_ff[b] >= div);
            always_ff @(posedge core_clk) begin
                if (!rst_b) begin
                    div_cnt_ff[b] <= tip_pkg::DIV_RST;
                end else if (clkb_tick[b]) begin
                    div_cnt_ff[b] <= tip_pkg::DIV_RST;
                end else if (src_edge) begin
                    div_cnt_ff[b] <= div_cnt_ff[b] + 8'h01;
                end
            end
        end
    endgenerate

    genvar i;
    generate
        for (i = 0; i < NP; i++) begin : g_port
            localparam int W = tip_pkg::PORT_W[i];
            localparam logic [PW-1:0] MSK = PW'((64'h1 << W) - 64'h1);
            logic tick;
            logic here;
            logic time_ok;
            logic cond_ok;
            logic strb_ok;
            logic [PW-1:0] smp;
            logic [1:0] mode;
            assign tick = clkb_tick[clkb_sel_ff[i]];
            assign here = core_req && (core_sel == tip_pkg::SEL_W'(i));
            // full width always, even where pins belong elsewhere
            assign smp = pin_s2_ff & MSK;
            assign mode = cfg_cond_mode[2*i +: 2];
            assign time_ok = !timed_ff[i]
                || (cnt_ff[i] == time_ff[i]);
            assign strb_ok = !cfg_strb_in[i] || strb_s2_ff;
            always_comb begin
                case (mode)
                    tip_pkg::TIP_COND_EQ: cond_ok = (smp == cond_ff[i]);
                    tip_pkg::TIP_COND_NEQ: cond_ok = (smp != cond_ff[i]);
                    default: cond_ok = 1'b1;
                endcase
            end
            // an input read needs data; an output write needs room
            always_comb begin
                acc[i] = 1'b0;
                if (here) begin
                    case (core_cmd)
                        tip_pkg::TIP_CMD_IN: acc[i] = full_ff[i] && !cfg_out[i];
                        tip_pkg::TIP_CMD_OUT: acc[i] = !full_ff[i] && cfg_out[i];
                        default: acc[i] = 1'b1;
                    endcase
                end
            end

            always_ff @(posedge core_clk) begin
                if (!rst_b) begin
                    cnt_ff[i] <= tip_pkg::CNT_RST;
                end else if (tick) begin
                    cnt_ff[i] <= cnt_ff[i] + 16'h0001;
                end
            end

            always_ff @(posedge core_clk) begin
                if (!rst_b) begin
                    clkb_sel_ff[i] <= tip_pkg::CLKB_RST;
                    time_ff[i] <= tip_pkg::CNT_RST;
                    cond_ff[i] <= tip_pkg::DATA_RST;
                end else if (here) begin
                    if (core_cmd == tip_pkg::TIP_CMD_SET_CLKB) begin
                        clkb_sel_ff[i] <= core_wdata[tip_pkg::SEL_W-1:0];
                    end else if (core_cmd == tip_pkg::TIP_CMD_SET_TIME) begin
                        time_ff[i] <= core_wdata[CW-1:0];
                    end else if (core_cmd == tip_pkg::TIP_CMD_SET_COND) begin
                        cond_ff[i] <= core_wdata & MSK;
                    end
                end
            end

            // serdes stage and transfer register form the buffer
            always_ff @(posedge core_clk) begin
                if (!rst_b) begin
                    xfer_ff[i] <= tip_pkg::DATA_RST;
                    sd_ff[i] <= tip_pkg::DATA_RST;
                    drv_ff[i] <= tip_pkg::DATA_RST;
                    ts_ff[i] <= tip_pkg::CNT_RST;
                    full_ff[i] <= 1'b0;
                    sd_full_ff[i] <= 1'b0;
                    timed_ff[i] <= 1'b0;
                    strb_pulse_ff[i] <= 1'b0;
                    port_evt_ff[i] <= 1'b0;
                end else begin
                    strb_pulse_ff[i] <= 1'b0;
                    port_evt_ff[i] <= 1'b0;
                    if (!cfg_out[i]) begin
                        if (tick && time_ok && strb_ok && cond_ok
                            && cfg_en[i] && !sd_full_ff[i]) begin
                            sd_ff[i] <= smp;
                            sd_full_ff[i] <= 1'b1;
                            ts_ff[i] <= cnt_ff[i];
                            timed_ff[i] <= 1'b0;
                        end else if (sd_full_ff[i] && !full_ff[i]) begin
                            xfer_ff[i] <= sd_ff[i];
                            sd_full_ff[i] <= 1'b0;
                            full_ff[i] <= 1'b1;
                            port_evt_ff[i] <= 1'b1;
                        end
                        if (acc[i] && core_cmd == tip_pkg::TIP_CMD_IN) begin
                            full_ff[i] <= 1'b0;
                        end
                    end else begin
                        if (acc[i] && core_cmd == tip_pkg::TIP_CMD_OUT) begin
                            xfer_ff[i] <= core_wdata & MSK;
                            full_ff[i] <= 1'b1;
                        end else if (full_ff[i] && !sd_full_ff[i]) begin
                            sd_ff[i] <= xfer_ff[i];
                            full_ff[i] <= 1'b0;
                            sd_full_ff[i] <= 1'b1;
                        end
                        if (tick && time_ok && sd_full_ff[i] && cfg_en[i]) begin
                            drv_ff[i] <= sd_ff[i];
                            sd_full_ff[i] <= 1'b0;
                            ts_ff[i] <= cnt_ff[i];
                            timed_ff[i] <= 1'b0;
                            strb_pulse_ff[i] <= cfg_strb_out[i];
                            port_evt_ff[i] <= 1'b1;
                        end
                    end
                    // a new arm outlives the disarm of a coinciding transfer
                    if (here && core_cmd == tip_pkg::TIP_CMD_SET_TIME) begin
                        timed_ff[i] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // pin ownership: link first, then narrowest enabled port
    always_comb begin
        nxt_pin_out = tip_pkg::DATA_RST;
        nxt_pin_oe = tip_pkg::DATA_RST;
        for (int p = 0; p < PW; p++) begin
            logic owned;
            owned = 1'b0;
            for (int k = 0; k < NP; k++) begin
                if (!owned && cfg_en[k] && p < tip_pkg::PORT_W[k]) begin
                    owned = 1'b1;
                    if (cfg_out[k]) begin
                        if (cfg_oc[k]) begin
                            nxt_pin_oe[p] = !drv_ff[k][p];
                        end else begin
                            nxt_pin_oe[p] = 1'b1;
                            nxt_pin_out[p] = drv_ff[k][p];
                        end
                    end
                end
            end
            // link holds these pins, so no port may drive them
            if (link_en && link_pin_mask[p]) begin
                nxt_pin_oe[p] = 1'b0;
                nxt_pin_out[p] = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pin_out_ff <= tip_pkg::DATA_RST;
            pin_oe_ff <= tip_pkg::DATA_RST;
            strobe_output_ff <= 1'b0;
        end else begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff <= nxt_pin_oe;
            strobe_output_ff <= |strb_pulse_ff;
        end
    end

    // answer mux; out-of-range select reads zero and is refused
    always_comb begin
        nxt_rdata = tip_pkg::DATA_RST;
        nxt_ts = tip_pkg::CNT_RST;
        for (int k = 0; k < NP; k++) begin
            if (core_sel == tip_pkg::SEL_W'(k)) begin
                nxt_ts = ts_ff[k];
                if (core_cmd == tip_pkg::TIP_CMD_GET_COUNT) begin
                    nxt_rdata = {16'h0000, cnt_ff[k]};
                end else begin
                    nxt_rdata = xfer_ff[k];
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            core_ack_ff <= 1'b0;
            core_ok_ff <= 1'b0;
            core_rdata_ff <= tip_pkg::DATA_RST;
            core_ts_ff <= tip_pkg::CNT_RST;
        end else begin
            core_ack_ff <= core_req;
            core_ok_ff <= |acc;
            core_rdata_ff <= nxt_rdata;
            core_ts_ff <= nxt_ts;
        end
    end
endmodule
